// >>> usb_ctrl_pkg.sv
// Package: register map, field layout and event carriers of the USB control/status block.
package usb_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_INT_MASK = 3'h0;
  localparam logic [2:0] OFS_CONTROL  = 3'h1;
  localparam logic [2:0] OFS_DEV_ADDR = 3'h2;
  localparam logic [2:0] OFS_XFER_ST  = 3'h3;
  localparam logic [2:0] OFS_EP0_CTRL = 3'h4;
  localparam logic [2:0] OFS_INT_STAT = 3'h5;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_RESUME_DET = 7;
  localparam int CTL_BUS_RST    = 6;
  localparam int CTL_RESUME_DRV = 3;
  localparam int CTL_PWR_DOWN   = 2;
  localparam int CTL_FORCE_SUSPEND      = 1;
  localparam int CTL_FORCE_RESET       = 0;
  localparam int IST_ERROR      = 4;
  localparam int IST_RESET      = 1;
  localparam logic [7:0] CONTROL_RESET   = 8'h06;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam logic [7:0] CONTROL_WR_MASK = 8'h0F;
  localparam logic [7:0] EP0_WR_MASK     = 8'h77;
  localparam logic [7:0] ADDR_WR_MASK    = 8'h7F;
  localparam logic [7:0] MASK_WR_MASK    = 8'hBF;
  localparam logic [7:0] IST_CLR_MASK    = 8'h3F;

  localparam logic [1:0] STAT_DISABLED = 2'h0;
  localparam logic [1:0] STAT_STALL    = 2'h1;
  localparam logic [1:0] STAT_NAK      = 2'h2;
  localparam logic [1:0] STAT_VALID    = 2'h3;
  localparam logic [1:0] PID_OUT       = 2'h0;
  localparam logic [1:0] PID_IN        = 2'h2;
  localparam logic [1:0] PID_SETUP     = 2'h3;

  // Events delivered by the serial engine, one core_clk cycle each.
  typedef struct packed {
    logic       bus_reset;
    logic       resume_seen;
    logic       activity;
    logic       suspend_req;
    logic       sof;
    logic       error;
    logic [2:0] error_code;
    logic       ep0_token;
    logic [1:0] ep0_pid;
    logic       ep0_ok;
    logic       ep0_tx_ack;
    logic       ep0_rx_data;
    logic       ep0_rx_tog;
    logic       epn_ok;
    logic [1:0] epn_num;
    logic       epn_in;
    logic       epn_ack;
  } link_event_type;

endpackage

// >>> usb_device_control_status.sv
// USB device control and status registers with endpoint 0 control.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Interrupt request when mask bit, status flag set and CPU mask clear.
// - Control register reads 0x06 after chip reset.
// - Resume detected bit 7 set when resume starts while suspended.
// - Bus reset seen bit 6 set when a bus reset begins.
// - Resume bit 3 drives resume signalling while set during suspend.
// - Power-down bit 2 turns the transceiver regulator off.
// - Force suspend bit 1 suspends; hardware clears it on bus activity.
// - Force reset holds interface in reset; release raises reset interrupt.
// - Device address is seven bits; bit 7 reads zero.
// - Any USB reset clears the device address.
// - Status bits 7:6 hold upper PID bits of last endpoint 0 token.
// - Status bit 5 records direction of endpoint 1 or 2 transfer.
// - Status bits 4:3 hold endpoint number needing attention.
// - Status bits 2:0 hold the error type code.
// - Error code loads on error and clears with error flag.
// - USB reset clears endpoint 0 bits 6:4 and 2:0, not bit 7.
// - Endpoint 0 transfer-ok flag set by hardware, cleared by software.
// - Transmit toggle set on SETUP, toggles on ACK, software writable.
// - Transmit status: disabled, stall, nak, valid.
// - Correct endpoint 0 transfer forces both status fields to NAK.
// - Receive toggle cleared on SETUP, toggles on matching good data.
// - Receive status: disabled, stall, nak, valid.
// - SETUP on enabled endpoint 0 is acked and both fields become NAK.
module usb_device_control_status
  import usb_ctrl_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           reset,
  input  wire logic           clk_en,
  input  wire logic [2:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  input  wire logic           cpu_int_mask,
  input  wire link_event_type link_ev,
  output logic                irq,
  output logic                resume_drive,
  output logic                regulator_off,
  output logic                suspended,
  output logic                usb_held_reset,
  output logic      [6:0]     dev_address,
  output logic      [1:0]     ep0_tx_stat,
  output logic      [1:0]     ep0_rx_stat,
  output logic                ep0_tx_toggle,
  output logic                ep0_rx_toggle,
  output logic                ep0_setup_ack
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mask_r;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic [6:0] addr_r;
  logic [7:0] xst_r;
  logic [7:0] xst_nxt;
  logic [7:0] ep0_r;
  logic [7:0] ep0_nxt;
  logic [7:0] ist_r;
  logic [7:0] ist_nxt;
  logic [7:0] rdata_r;
  logic       irq_r;
  logic       ack_r;
  logic       resume_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_mask = reg_wr && (reg_addr == OFS_INT_MASK);
  wire wr_ctl  = reg_wr && (reg_addr == OFS_CONTROL);
  wire wr_addr = reg_wr && (reg_addr == OFS_DEV_ADDR);
  wire wr_ep0  = reg_wr && (reg_addr == OFS_EP0_CTRL);
  wire wr_ist  = reg_wr && (reg_addr == OFS_INT_STAT);
  wire force_reset_on = ctl_r[CTL_FORCE_RESET];
  // A forced reset clears the address and endpoint 0 like a bus reset for as long as it is held.
  wire usb_rst = link_ev.bus_reset || force_reset_on;
  wire force_reset_release = wr_ctl && force_reset_on && !reg_wdata[CTL_FORCE_RESET];
  // A SETUP is taken while either direction is enabled.
  wire ep0_live = (ep0_r[5:4] != STAT_DISABLED) || (ep0_r[1:0] != STAT_DISABLED);
  wire setup_tok = link_ev.ep0_token && (link_ev.ep0_pid == PID_SETUP);
  wire setup_ok = setup_tok && ep0_live && !usb_rst;
  wire rx_match = link_ev.ep0_rx_data && (link_ev.ep0_rx_tog == ep0_r[2]);
  // Only a real one-to-zero clear of the error flag wipes the code.
  wire err_clr = wr_ist && !reg_wdata[IST_ERROR] && ist_r[IST_ERROR];
  wire in_susp = ctl_r[CTL_FORCE_SUSPEND];

  // ----------------------------------------------------------------
  // Control register next value
  // ----------------------------------------------------------------
  always_comb begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = (ctl_r & ~CONTROL_WR_MASK) | (reg_wdata & CONTROL_WR_MASK);
    end
    if (link_ev.resume_seen && in_susp) begin
      ctl_nxt[CTL_RESUME_DET] = 1'b1;
    end
    if (link_ev.bus_reset) begin
      ctl_nxt[CTL_BUS_RST] = 1'b1;
    end
    if (link_ev.activity || link_ev.resume_seen || link_ev.bus_reset) begin
      ctl_nxt[CTL_FORCE_SUSPEND] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer status next value
  // ----------------------------------------------------------------
  always_comb begin
    xst_nxt = xst_r;
    if (link_ev.ep0_token) begin
      xst_nxt[7:6] = link_ev.ep0_pid;
    end
    if (link_ev.epn_ok) begin
      xst_nxt[5] = link_ev.epn_in;
      xst_nxt[4:3] = link_ev.epn_num;
    end else if (link_ev.ep0_ok) begin
      xst_nxt[4:3] = 2'h0;
    end
    if (err_clr) begin
      xst_nxt[2:0] = 3'h0;
    end
    if (link_ev.error) begin
      xst_nxt[2:0] = link_ev.error_code;
    end
  end

  // ----------------------------------------------------------------
  // Endpoint 0 next value
  // ----------------------------------------------------------------
  always_comb begin
    ep0_nxt = ep0_r;
    if (wr_ep0) begin
      ep0_nxt = (ep0_r & ~EP0_WR_MASK) | (reg_wdata & EP0_WR_MASK);
      if (!reg_wdata[7]) begin
        ep0_nxt[7] = 1'b0;
      end
    end
    if (link_ev.ep0_tx_ack) begin
      ep0_nxt[6] = ~ep0_r[6];
    end
    if (rx_match) begin
      ep0_nxt[2] = ~ep0_r[2];
    end
    if (link_ev.ep0_ok) begin
      ep0_nxt[7] = 1'b1;
      ep0_nxt[5:4] = STAT_NAK;
      ep0_nxt[1:0] = STAT_NAK;
    end
    if (setup_ok) begin
      ep0_nxt[6] = 1'b1;
      ep0_nxt[2] = 1'b0;
      ep0_nxt[5:4] = STAT_NAK;
      ep0_nxt[1:0] = STAT_NAK;
    end
    if (usb_rst) begin
      ep0_nxt[6:0] = 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: hardware set wins over a software clear
  // ----------------------------------------------------------------
  always_comb begin
    ist_nxt = ist_r;
    if (wr_ist) begin
      ist_nxt = ist_r & (reg_wdata | ~IST_CLR_MASK);
    end
    ist_nxt[7] = ep0_nxt[7];
    ist_nxt[6] = 1'b0;
    if (setup_ok && ep0_r[7]) begin
      ist_nxt[5] = 1'b1;
    end
    if (link_ev.error) begin
      ist_nxt[4] = 1'b1;
    end
    if (link_ev.suspend_req && !in_susp) begin
      ist_nxt[3] = 1'b1;
    end
    if (in_susp && (link_ev.activity || link_ev.resume_seen || link_ev.bus_reset)) begin
      ist_nxt[2] = 1'b1;
    end
    if (link_ev.bus_reset || force_reset_release) begin
      ist_nxt[1] = 1'b1;
    end
    if (link_ev.sof) begin
      ist_nxt[0] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
    (reg_addr == OFS_INT_MASK) ? mask_r :
    (reg_addr == OFS_CONTROL)  ? ctl_r :
    (reg_addr == OFS_DEV_ADDR) ? {1'b0, addr_r} :
    (reg_addr == OFS_XFER_ST)  ? xst_r :
    (reg_addr == OFS_EP0_CTRL) ? ep0_r :
    (reg_addr == OFS_INT_STAT) ? ist_r : ZERO_BYTE;
  // The request is registered one cycle behind the flags so that it cannot glitch.
  wire irq_nxt = ((mask_r & ist_r) != ZERO_BYTE) && !cpu_int_mask;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_r  <= ZERO_BYTE;
      ctl_r   <= CONTROL_RESET;
      addr_r  <= 7'h00;
      xst_r   <= ZERO_BYTE;
      ep0_r   <= ZERO_BYTE;
      ist_r   <= ZERO_BYTE;
      rdata_r <= ZERO_BYTE;
      irq_r   <= 1'b0;
      ack_r   <= 1'b0;
      resume_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_mask) begin
        mask_r <= reg_wdata & MASK_WR_MASK;
      end
      ctl_r <= ctl_nxt;
      if (usb_rst) begin
        addr_r <= 7'h00;
      end else if (wr_addr) begin
        addr_r <= reg_wdata[6:0];
      end
      xst_r   <= xst_nxt;
      ep0_r   <= ep0_nxt;
      ist_r   <= ist_nxt;
      // Read data is zero after each enabled cycle without a read; while frozen it holds its value.
      rdata_r <= reg_rd ? rd_mux : ZERO_BYTE;
      irq_r   <= irq_nxt;
      ack_r   <= setup_ok;
      // Built from the next control value so the pin tracks the register yet leaves a flop.
      resume_r <= ctl_nxt[CTL_RESUME_DRV] & ctl_nxt[CTL_FORCE_SUSPEND];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Resume is only driven while suspended; software times its length.
  assign resume_drive   = resume_r;
  assign regulator_off  = ctl_r[CTL_PWR_DOWN];
  assign suspended      = ctl_r[CTL_FORCE_SUSPEND];
  assign usb_held_reset = ctl_r[CTL_FORCE_RESET];
  assign dev_address    = addr_r;
  assign ep0_tx_stat    = ep0_r[5:4];
  assign ep0_rx_stat    = ep0_r[1:0];
  assign ep0_tx_toggle  = ep0_r[6];
  assign ep0_rx_toggle  = ep0_r[2];
  assign ep0_setup_ack  = ack_r;
  assign irq            = irq_r;
  assign reg_rdata      = rdata_r;

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // An accepted SETUP, and what it must leave one cycle later: toggles
  // primed, both directions parked on NAK and the acknowledge raised.
  sequence setup_taken_seq;
    clk_en && setup_ok;
  endsequence
  sequence setup_applied_seq;
    ep0_tx_toggle && !ep0_rx_toggle && ep0_setup_ack
      && ep0_tx_stat == STAT_NAK && ep0_rx_stat == STAT_NAK;
  endsequence

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_irq_cause: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && ((mask_r & ist_r) != ZERO_BYTE) && !cpu_int_mask |=> irq)
    else $error("interrupt not raised");
  chk_bus_reset_flag: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.bus_reset |=> ctl_r[CTL_BUS_RST] && addr_r == 7'h00)
    else $error("bus reset not recorded");
  chk_resume_flag: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.resume_seen && in_susp |=> ctl_r[CTL_RESUME_DET] && !suspended)
    else $error("resume not recorded");
  chk_force_reset_irq: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && force_reset_release |=> ist_r[IST_RESET] && !usb_held_reset)
    else $error("forced reset release without reset flag");
  chk_ep0_reset: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && usb_rst && !link_ev.ep0_ok && !wr_ep0
      |=> ep0_r[6:0] == 7'h00 && ep0_r[7] == $past(ep0_r[7]))
    else $error("endpoint 0 not cleared by reset");
  chk_ep0_nak: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.ep0_ok && !usb_rst |=> ep0_tx_stat == STAT_NAK
      && ep0_rx_stat == STAT_NAK && ep0_r[7])
    else $error("endpoint 0 not forced to nak");
  chk_setup_tog: assert property (@(posedge core_clk) disable iff (reset)
    setup_taken_seq |=> setup_applied_seq)
    else $error("setup toggles wrong");
  chk_err_code: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.error |=> xst_r[2:0] == $past(link_ev.error_code) && ist_r[IST_ERROR])
    else $error("error code not loaded");
  chk_addr_msb: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && reg_rd && reg_addr == OFS_DEV_ADDR |=> !reg_rdata[7])
    else $error("address bit 7 not zero");
  chk_ack_pulse: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && !setup_ok |=> !ep0_setup_ack)
    else $error("setup acknowledge without setup");
  chk_force_suspend_clear: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.activity |=> !suspended)
    else $error("suspend not left on bus activity");
  chk_resume_gate: assert property (@(posedge core_clk) disable iff (reset)
    !suspended |-> !resume_drive)
    else $error("resume driven outside suspend");
  chk_addr_reset: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && usb_rst |=> dev_address == 7'h00)
    else $error("address not cleared by reset");
  chk_pwr_down: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && wr_ctl |=> regulator_off == $past(reg_wdata[CTL_PWR_DOWN]))
    else $error("regulator control not applied");
  chk_tx_toggle: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.ep0_tx_ack && !setup_ok && !usb_rst && !wr_ep0
      |=> ep0_tx_toggle != $past(ep0_tx_toggle))
    else $error("transmit toggle not flipped on ack");
  chk_token_pid: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && link_ev.ep0_token |=> xst_r[7:6] == $past(link_ev.ep0_pid))
    else $error("token bits not captured");
  chk_err_clear: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && err_clr && !link_ev.error |=> xst_r[2:0] == 3'h0 && !ist_r[IST_ERROR])
    else $error("error code not cleared with flag");
  chk_rst_sticky: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && ctl_r[CTL_BUS_RST] |=> ctl_r[CTL_BUS_RST])
    else $error("bus reset flag lost");
  chk_reserved_zero: assert property (@(posedge core_clk) disable iff (reset)
    ctl_r[5:4] == 2'h0 && ep0_r[3] == 1'b0
      && mask_r[6] == 1'b0 && ist_r[6] == 1'b0)
    else $error("reserved bit not zero");
  // A frozen cycle must leave the registers and the read port untouched.
  chk_freeze_hold: assert property (@(posedge core_clk) disable iff (reset)
    !clk_en |=> $stable(ctl_r) && $stable(ep0_r) && $stable(addr_r) && $stable(reg_rdata))
    else $error("state moved while frozen");

endmodule

// >>> usb_device_control_status_tb_top.sv
// Self-checking testbench of the USB device control and status block.
`timescale 1ns/1ps
module usb_device_control_status_tb_top
  import usb_ctrl_pkg::*;
;
  logic           core_clk, reset, clk_en, reg_wr, reg_rd, cpu_int_mask;
  logic [2:0]     reg_addr;
  logic [7:0]     reg_wdata, reg_rdata, rv;
  logic           irq, resume_drive, regulator_off, suspended, usb_held_reset;
  logic           ep0_tx_toggle, ep0_rx_toggle, ep0_setup_ack;
  logic [6:0]     dev_address;
  logic [1:0]     ep0_tx_stat, ep0_rx_stat;
  link_event_type link_ev;
  int             bad_count, checks_done;
  logic [2:0]     codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [1:0]     pids [3] = '{2'h0, 2'h2, 2'h3};

  usb_device_control_status usb_device_control_status_inst (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_int_mask(cpu_int_mask), .link_ev(link_ev), .irq(irq),
    .resume_drive(resume_drive), .regulator_off(regulator_off), .suspended(suspended),
    .usb_held_reset(usb_held_reset), .dev_address(dev_address),
    .ep0_tx_stat(ep0_tx_stat), .ep0_rx_stat(ep0_rx_stat),
    .ep0_tx_toggle(ep0_tx_toggle), .ep0_rx_toggle(ep0_rx_toggle),
    .ep0_setup_ack(ep0_setup_ack)
  );
  usb_host_event_model usb_host_event_model_inst (.core_clk(core_clk), .link_ev(link_ev));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
    chk(rv & m, exp);
  endtask
  task automatic ev(input link_event_type e);
    usb_host_event_model_inst.send(e);
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    {reset, clk_en, reg_wr, reg_rd, cpu_int_mask, reg_addr, reg_wdata} = {2'b11, 14'h0000};
    bad_count = 0;
    checks_done = 0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rchk(3'(i), 8'hFF, (i == 1) ? 8'h06 : 8'h00);
    chk({6'h00, regulator_off, suspended}, 8'h03);
    wr(3'h0, 8'hFF);
    rchk(3'h0, 8'hFF, 8'hBF);
    wr(3'h6, 8'hFF);
    rchk(3'h6, 8'hFF, 8'h00);
    wr(3'h2, 8'h85);
    rchk(3'h2, 8'hFF, 8'h05);
    chk({1'b0, dev_address}, 8'h05);
    clk_en <= 1'b0;
    wr(3'h2, 8'h11);
    clk_en <= 1'b1;
    rchk(3'h2, 8'hFF, 8'h05);
    wr(3'h1, 8'h32);
    chk({6'h00, regulator_off, suspended}, 8'h01);
    rchk(3'h1, 8'hFF, 8'h02);
    cyc(60);
    wr(3'h1, 8'h0A);
    chk({7'h00, resume_drive}, 8'h01);
    wr(3'h1, 8'h02);
    chk({7'h00, resume_drive}, 8'h00);
    ev(link_event_type'{activity: 1'b1, default: '0});
    rchk(3'h1, 8'h0F, 8'h00);
    chk({7'h00, suspended}, 8'h00);
    wr(3'h1, 8'h08);
    chk({7'h00, resume_drive}, 8'h00);
    wr(3'h1, 8'h02);
    ev(link_event_type'{resume_seen: 1'b1, default: '0});
    rchk(3'h1, 8'h80, 8'h80);
    foreach (codes[i]) begin
      ev(link_event_type'{error: 1'b1, error_code: codes[i], default: '0});
      rchk(3'h3, 8'h07, {5'h00, codes[i]});
      wr(3'h5, 8'hEF);
      rchk(3'h3, 8'h07, 8'h00);
    end
    ev(link_event_type'{epn_ok: 1'b1, epn_num: 2'h1, epn_in: 1'b1, default: '0});
    rchk(3'h3, 8'h38, 8'h28);
    ev(link_event_type'{epn_ok: 1'b1, epn_num: 2'h2, default: '0});
    rchk(3'h3, 8'h38, 8'h10);
    wr(3'h4, 8'h33);
    foreach (pids[i]) begin
      ev(link_event_type'{ep0_token: 1'b1, ep0_pid: pids[i], default: '0});
      if (i == 2) chk({7'h00, ep0_setup_ack}, 8'h01);
      rchk(3'h3, 8'hC0, {pids[i], 6'h00});
    end
    rchk(3'h4, 8'hFF, 8'h62);
    ev(link_event_type'{ep0_tx_ack: 1'b1, default: '0});
    chk({7'h00, ep0_tx_toggle}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      ev(link_event_type'{ep0_rx_data: 1'b1, default: '0});
      chk({7'h00, ep0_rx_toggle}, 8'h01);
    end
    wr(3'h4, 8'h77);
    ev(link_event_type'{ep0_ok: 1'b1, default: '0});
    rchk(3'h4, 8'hFF, 8'hE6);
    rchk(3'h3, 8'h18, 8'h00);
    wr(3'h4, 8'hF7);
    rchk(3'h4, 8'hFF, 8'hF7);
    wr(3'h2, 8'h7F);
    ev(link_event_type'{bus_reset: 1'b1, default: '0});
    rchk(3'h4, 8'hFF, 8'h80);
    rchk(3'h2, 8'hFF, 8'h00);
    rchk(3'h1, 8'h40, 8'h40);
    wr(3'h4, 8'h00);
    rchk(3'h4, 8'hFF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(3'h4, 8'(i * 17));
      chk({4'h0, ep0_tx_stat, ep0_rx_stat}, 8'(i * 5));
    end
    wr(3'h0, 8'h02);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'h2A);
    wr(3'h1, 8'h01);
    chk({7'h00, usb_held_reset}, 8'h01);
    rchk(3'h2, 8'hFF, 8'h00);
    wr(3'h1, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    cpu_int_mask <= 1'b1;
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    cpu_int_mask <= 1'b0;
    wr(3'h0, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    wr(3'h0, 8'h02);
    wr(3'h5, 8'hFD);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    end_of_test();
  end
endmodule

// >>> usb_host_event_model.sv
// Model of the host-side serial engine that delivers link events to the block.
`timescale 1ns/1ps
module usb_host_event_model
  import usb_ctrl_pkg::*;
(
  input  wire logic     core_clk,
  output link_event_type link_ev
);
  initial link_ev = '0;

  // Each event is a one-cycle pulse; the carrier falls back to idle at once,
  // so a stale event can never be counted twice.
  task automatic send(input link_event_type e);
    @(posedge core_clk);
    link_ev <= e;
    @(posedge core_clk);
    link_ev <= '0;
  endtask
endmodule
